// File: dual_serial_port_params.svh
// Constants of the dual serial register port
`ifndef DUAL_SERIAL_PORT_PARAMS_SVH
`define DUAL_SERIAL_PORT_PARAMS_SVH

`define BYTE_W          8
`define REG_INDEX_W     8
`define LAST_BIT        3'h7
`define FIRST_BIT       3'h0
`define ADDR_UPPER_BITS 6'h35
`define INDEX_STEP      8'h01
`define INDEX_HOLD      8'h00
`define CLK_RATE_KHZ    50000
`define FAST_MODE_KHZ   400
`define FAST_BIT_CYCLES (`CLK_RATE_KHZ / `FAST_MODE_KHZ)

`endif

// File: dual_serial_port_pkg.sv
// Types shared by the dual serial register port
`default_nettype none
package dual_serial_port_pkg;
  typedef enum logic [2:0] {
    st_idle, st_rx, st_ack_wait, st_ack, st_load, st_tx, st_host_ack, st_next
  } i2c_state_t;
  typedef enum logic [1:0] {kind_addr, kind_index, kind_data} byte_kind_t;
endpackage : dual_serial_port_pkg
`default_nettype wire

// File: dual_serial_register_port.sv
// Shared-pin two-wire and SPI slave giving access to 8-bit registers
//
// Summary of operation
// RL1: Chip select high picks two-wire, low SPI
// RL2: Disable input switches the two-wire slave off
// RL3: Start is data falling with clock high
// RL4: First byte holds address and direction bit
// RL5: Own address is 110101 plus select pin
// RL6: Device pulls data low in the ack slot after its address and each written byte
// RL7: Byte after write address is register index
// RL8: Repeated start with read address returns data
// RL9: Missing host acknowledge ends read data drive
// RL10: Bytes are eight bits, most significant first
// RL11: Receiver may hold the clock low to stall
// RL12: Unmatched address leaves data line high
// RL13: Stop is data rising with clock high
// RL14: Two-wire slave runs up to fast mode
// RL15: Host frames SPI with chip select low
// RL16: SPI drives on falling, samples on rising
// RL17: SPI command is sixteen plus eight per byte
// RL18: SPI bit zero is direction, read drives at 8
// RL19: SPI index then data, most significant first
// RL20: Auto-increment selects same or next index
// RL21: Three-wire mode returns read data on data pin
// RL22: Four-wire uses output pin; release when idle
`default_nettype none
`include "dual_serial_port_params.svh"
module dual_serial_register_port (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   serial_port_clock_i,
  input  wire logic                   chip_select_n_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_n_o,
  output logic                        scl_o,
  output logic                        scl_oe_n_o,
  input  wire logic                   address_select_pin_i,
  output logic                        sdo_o,
  output logic                        sdo_oe_n_o,
  input  wire logic                   two_wire_disable_i,
  input  wire logic                   three_wire_select_i,
  input  wire logic                   auto_increment_i,
  output logic [`REG_INDEX_W-1:0]     reg_index_o,
  output logic [`BYTE_W-1:0]          reg_wdata_o,
  output logic                        reg_write_o,
  output logic                        reg_read_o,
  input  wire logic [`BYTE_W-1:0]     reg_rdata_i,
  output logic                        bus_busy_o
);
  localparam int BIT_CYCLES = `FAST_BIT_CYCLES;

  dual_serial_port_pkg::i2c_state_t state;
  dual_serial_port_pkg::byte_kind_t kind;
  logic [3:0]              pin_s1;
  logic [3:0]              pin_s2;
  logic                    scl_d;
  logic                    sda_d;
  logic                    link_rst;
  logic                    tog_s1;
  logic                    tog_s2;
  logic                    tog_d;
  logic                    spi_tog;
  logic                    spi_header;
  logic [`BYTE_W-1:0]      spi_word;
  logic                    spi_bit;
  logic                    spi_drive;
  logic                    spi_rw;
  logic [`REG_INDEX_W-1:0] idx;
  logic [`BYTE_W-1:0]      read_hold;
  logic                    data_ready;
  logic [2:0]              bit_cnt;
  logic [`BYTE_W-1:0]      rx_shift;
  logic [`BYTE_W-1:0]      tx_shift;
  logic                    sda_drive;
  logic                    scl_hold;
  logic                    rw_read;
  logic                    busy;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Oversampling at 50 MHz leaves over 100 cycles per fast-mode bit [RL14]
  wire [3:0] pin_raw = {address_select_pin_i, chip_select_n_i, sda_i, serial_port_clock_i};

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      scl_d  <= pin_s2[0];
      sda_d  <= pin_s2[1];
    end
  end

  wire scl_now  = pin_s2[0];
  wire sda_now  = pin_s2[1];
  wire cs_now   = pin_s2[2];
  wire asel_now = pin_s2[3];

  // ----------------------------------------
  // SPI event crossing
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      link_rst <= 1'b1;
      tog_s1   <= 1'b0;
      tog_s2   <= 1'b0;
      tog_d    <= 1'b0;
    end
    else
    begin
      link_rst <= 1'b0;
      tog_s1   <= spi_tog;
      tog_s2   <= tog_s1;
      tog_d    <= tog_s2;
    end
  end

  wire spi_event = tog_s2 ^ tog_d;

  spi_link_engine spi (
    .port_clk_i     (serial_port_clock_i),
    .cs_n_i         (chip_select_n_i),
    .link_rst_i     (link_rst),
    .sdi_i          (sda_i),
    .read_word_i    (read_hold),
    .event_toggle_o (spi_tog),
    .event_header_o (spi_header),
    .event_word_o   (spi_word),
    .out_bit_o      (spi_bit),
    .out_drive_o    (spi_drive)
  );

  // ----------------------------------------
  // Two-wire decode
  // ----------------------------------------
  wire       i2c_on     = cs_now && !two_wire_disable_i; // [RL1] [RL2]
  wire       scl_rise   = scl_now && !scl_d;
  wire       scl_fall   = !scl_now && scl_d;
  wire       start_det  = i2c_on && scl_now && scl_d && sda_d && !sda_now; // [RL3]
  wire       stop_det   = i2c_on && scl_now && scl_d && !sda_d && sda_now; // [RL13]
  wire [7:0] rx_byte    = {rx_shift[`BYTE_W-2:0], sda_now}; // [RL10]
  wire       in_rx      = (state == dual_serial_port_pkg::st_rx);
  wire       byte_done  = in_rx && scl_rise && (bit_cnt == `LAST_BIT);
  wire [6:0] own_addr   = {`ADDR_UPPER_BITS, asel_now}; // [RL5]
  wire       addr_match = (rx_byte[7:1] == own_addr); // [RL4]
  wire       take_addr  = byte_done && (kind == dual_serial_port_pkg::kind_addr);
  wire       take_index = byte_done && (kind == dual_serial_port_pkg::kind_index); // [RL7]
  wire       i2c_write  = byte_done && (kind == dual_serial_port_pkg::kind_data);
  wire       in_hack    = (state == dual_serial_port_pkg::st_host_ack);
  wire       host_acked = in_hack && scl_rise && !sda_now; // [RL9]
  wire       i2c_read   = (take_addr && addr_match && rx_byte[0]) || host_acked; // [RL8]

  // ----------------------------------------
  // Register access and index stepping
  // ----------------------------------------
  wire       spi_hdr   = spi_event && spi_header;
  wire       spi_rd    = spi_event && (spi_header ? spi_word[`BYTE_W-1] : spi_rw); // [RL18]
  wire       spi_wr    = spi_event && !spi_header && !spi_rw;
  wire       do_read   = i2c_read || spi_rd;
  wire       do_write  = i2c_write || spi_wr;
  wire [7:0] step      = auto_increment_i ? `INDEX_STEP : `INDEX_HOLD; // [RL20]
  wire [7:0] spi_index = {1'b0, spi_word[6:0]}; // [RL19]
  wire [7:0] base      = take_index ? rx_byte : (spi_hdr ? spi_index : idx);
  wire [7:0] next_idx  = (do_read || do_write) ? base + step : base; // [RL20]
  wire [7:0] wdata_sel = i2c_write ? rx_byte : spi_word;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      idx         <= '0;
      reg_index_o <= '0;
      reg_wdata_o <= '0;
      reg_write_o <= 1'b0;
      reg_read_o  <= 1'b0;
      spi_rw      <= 1'b0;
    end
    else
    begin
      idx         <= next_idx;
      reg_write_o <= do_write;
      reg_read_o  <= do_read;
      if (do_read || do_write)
        reg_index_o <= base;
      if (do_write)
        reg_wdata_o <= wdata_sel;
      if (spi_hdr)
        spi_rw <= spi_word[`BYTE_W-1];
    end
  end

  // Fresh capture wins over the clear of a new request
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      read_hold  <= '0;
      data_ready <= 1'b0;
    end
    else
    begin
      if (reg_read_o)
        read_hold <= reg_rdata_i;
      data_ready <= reg_read_o || (data_ready && !do_read);
    end
  end

  // ----------------------------------------
  // Two-wire byte sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || !i2c_on) // [RL1] [RL2]
    begin
      state     <= dual_serial_port_pkg::st_idle;
      kind      <= dual_serial_port_pkg::kind_addr;
      bit_cnt   <= `FIRST_BIT;
      rx_shift  <= '0;
      tx_shift  <= '0;
      sda_drive <= 1'b0;
      scl_hold  <= 1'b0;
      rw_read   <= 1'b0;
      busy      <= 1'b0;
    end
    else if (start_det) // [RL3]
    begin
      state     <= dual_serial_port_pkg::st_rx;
      kind      <= dual_serial_port_pkg::kind_addr;
      bit_cnt   <= `FIRST_BIT;
      sda_drive <= 1'b0;
      scl_hold  <= 1'b0;
      busy      <= 1'b1;
    end
    else if (stop_det) // [RL13]
    begin
      state     <= dual_serial_port_pkg::st_idle;
      sda_drive <= 1'b0;
      scl_hold  <= 1'b0;
      busy      <= 1'b0;
    end
    else
    begin
      case (state)
        dual_serial_port_pkg::st_rx:
          if (scl_rise)
          begin
            rx_shift <= rx_byte; // [RL10]
            bit_cnt  <= bit_cnt + 3'h1;
            if (take_addr)
              rw_read <= rx_byte[0];
            // No match: stay off the line until the next start [RL12]
            if (byte_done)
              state <= (!take_addr || addr_match) ? dual_serial_port_pkg::st_ack_wait
                                                  : dual_serial_port_pkg::st_idle;
          end
        dual_serial_port_pkg::st_ack_wait:
          if (scl_fall)
          begin
            sda_drive <= 1'b1; // [RL6]
            state     <= dual_serial_port_pkg::st_ack;
          end
        dual_serial_port_pkg::st_ack:
          if (scl_fall)
          begin
            sda_drive <= 1'b0;
            bit_cnt   <= `FIRST_BIT;
            kind      <= (kind == dual_serial_port_pkg::kind_addr) ? dual_serial_port_pkg::kind_index
                                                                   : dual_serial_port_pkg::kind_data; // [RL7]
            state     <= rw_read ? dual_serial_port_pkg::st_load : dual_serial_port_pkg::st_rx; // [RL8]
          end
        dual_serial_port_pkg::st_load:
        begin
          // Clock is low here, so holding it stalls the host safely [RL11]
          scl_hold <= !data_ready;
          if (data_ready)
          begin
            tx_shift  <= read_hold;
            sda_drive <= !read_hold[`BYTE_W-1]; // [RL10]
            bit_cnt   <= `FIRST_BIT;
            state     <= dual_serial_port_pkg::st_tx;
          end
        end
        dual_serial_port_pkg::st_tx:
          if (scl_fall)
          begin
            if (bit_cnt == `LAST_BIT)
            begin
              sda_drive <= 1'b0;
              state     <= dual_serial_port_pkg::st_host_ack;
            end
            else
            begin
              bit_cnt   <= bit_cnt + 3'h1;
              tx_shift  <= {tx_shift[`BYTE_W-2:0], 1'b0};
              sda_drive <= !tx_shift[`BYTE_W-2];
            end
          end
        dual_serial_port_pkg::st_host_ack:
          if (scl_rise)
            state <= sda_now ? dual_serial_port_pkg::st_idle : dual_serial_port_pkg::st_next; // [RL9]
        dual_serial_port_pkg::st_next:
          if (scl_fall)
            state <= dual_serial_port_pkg::st_load;
        default:
          state <= dual_serial_port_pkg::st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  wire spi_sda_drive = three_wire_select_i && spi_drive; // [RL21]

  assign scl_o      = 1'b0;
  assign scl_oe_n_o = !(scl_hold && i2c_on); // [RL11]
  assign sda_o      = spi_sda_drive ? spi_bit : 1'b0;
  assign sda_oe_n_o = !(spi_sda_drive || (sda_drive && i2c_on)); // [RL6] [RL22]
  assign sdo_o      = spi_bit;
  assign sdo_oe_n_o = !(spi_drive && !three_wire_select_i); // [RL22]
  assign bus_busy_o = busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking main_cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_cs_low_idle : // [RL1]
  assert property (!cs_now |=> (state == dual_serial_port_pkg::st_idle) && !bus_busy_o)
    else $error("two-wire active with chip select low");

  a_disable_idle : // [RL2]
  assert property (two_wire_disable_i |=> (state == dual_serial_port_pkg::st_idle) && scl_oe_n_o)
    else $error("two-wire active while disabled");

  a_start_busy : // [RL3]
  assert property (start_det |=> bus_busy_o && in_rx && (bit_cnt == `FIRST_BIT))
    else $error("start not taken");

  a_foreign_addr : // [RL4] [RL12]
  assert property ((take_addr && rx_byte[7:1] != {`ADDR_UPPER_BITS, asel_now})
    |=> (state == dual_serial_port_pkg::st_idle) ##1 sda_oe_n_o)
    else $error("foreign address not ignored");

  a_own_address : // [RL5]
  assert property ((take_addr && rx_byte[7:2] == `ADDR_UPPER_BITS && rx_byte[1] == asel_now)
    |=> state == dual_serial_port_pkg::st_ack_wait)
    else $error("own address not accepted");

  a_ack_drives_low : // [RL6]
  assert property ((state == dual_serial_port_pkg::st_ack_wait) && scl_fall |=> !sda_oe_n_o)
    else $error("acknowledge not driven");

  a_index_loaded : // [RL7]
  assert property (take_index |=> idx == $past(rx_byte))
    else $error("index byte not loaded");

  a_read_fetch : // [RL8]
  assert property ((take_addr && addr_match && rx_byte[0]) |=> reg_read_o ##1 data_ready)
    else $error("read address did not fetch");

  a_nack_release : // [RL9]
  assert property ((in_hack && scl_rise && sda_now) |=> (state == dual_serial_port_pkg::st_idle) && sda_oe_n_o)
    else $error("data still driven after no acknowledge");

  a_tx_msb_first : // [RL10]
  assert property ((state == dual_serial_port_pkg::st_load) && data_ready |=> sda_oe_n_o == $past(read_hold[7]))
    else $error("first sent bit is not the top bit");

  a_stretch_bound : // [RL11] [RL14]
  assert property ($rose(scl_hold) |-> ##[1:BIT_CYCLES] !scl_hold)
    else $error("clock held low too long");

  a_stop_frees : // [RL13]
  assert property (stop_det |=> !bus_busy_o && (state == dual_serial_port_pkg::st_idle))
    else $error("stop did not free the bus");

  a_index_step : // [RL20]
  assert property (((do_read || do_write) && !take_index && !spi_hdr) |=> idx == $past(idx) + $past(step))
    else $error("index did not step as configured");

  a_three_wire_pin : // [RL21] [RL22]
  assert property ((spi_drive && three_wire_select_i) |-> !sda_oe_n_o && sdo_oe_n_o)
    else $error("three-wire read data on wrong pin");

endmodule : dual_serial_register_port
`default_nettype wire

// File: host_bus_model.sv
// Host master model driving the shared two-wire and SPI pins
`default_nettype none
module host_bus_model #(
  parameter int Q_NS    = 625,
  // Slow link clock: read data must cross into the system clock before bit 8
  parameter int HALF_NS = 160
) (
  input  wire logic sda_line_i,
  input  wire logic scl_line_i,
  input  wire logic sdo_line_i,
  output logic      sda_drive_o,
  output logic      scl_drive_o,
  output logic      cs_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sda_drive_o = 1'b1;
    scl_drive_o = 1'b1;
    cs_n_o      = 1'b1;
  end
  // Bounded so a stuck stretch cannot hang the run
  task automatic release_scl();
    int n;
    n = 0;
    scl_drive_o = 1'b1;
    while (scl_line_i !== 1'b1 && n < 500)
    begin
      #10;
      n++;
    end
  endtask : release_scl
  task automatic i2c_bit(input logic b, output logic s);
    sda_drive_o = b;
    #(Q_NS);
    release_scl();
    #(Q_NS);
    s = sda_line_i;
    #(Q_NS);
    scl_drive_o = 1'b0;
    #(Q_NS);
  endtask : i2c_bit
  task automatic i2c_start();
    sda_drive_o = 1'b1;
    #(Q_NS);
    release_scl();
    #(Q_NS);
    sda_drive_o = 1'b0;
    #(Q_NS);
    scl_drive_o = 1'b0;
    #(Q_NS);
  endtask : i2c_start
  task automatic i2c_stop();
    sda_drive_o = 1'b0;
    #(Q_NS);
    release_scl();
    #(Q_NS);
    sda_drive_o = 1'b1;
    #(Q_NS);
  endtask : i2c_stop
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rx[i]);
    i2c_bit(ack_in, ack);
  endtask : i2c_byte
  task automatic spi_select(input logic sel);
    cs_n_o = !sel;
    sda_drive_o = 1'b1;
    #(HALF_NS);
  endtask : spi_select
  task automatic spi_byte(input logic [7:0] tx, input logic three, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      scl_drive_o = 1'b0;
      sda_drive_o = tx[i];
      #(HALF_NS);
      scl_drive_o = 1'b1;
      rx[i] = three ? sda_line_i : sdo_line_i;
      #(HALF_NS);
    end
  endtask : spi_byte
endmodule : host_bus_model
`default_nettype wire

// File: spi_link_engine.sv
// SPI slave shifter running on the serial port clock
`default_nettype none
`include "dual_serial_port_params.svh"
module spi_link_engine (
  input  wire logic               port_clk_i,
  input  wire logic               cs_n_i,
  input  wire logic               link_rst_i,
  input  wire logic               sdi_i,
  input  wire logic [`BYTE_W-1:0] read_word_i,
  output logic                    event_toggle_o,
  output logic                    event_header_o,
  output logic [`BYTE_W-1:0]      event_word_o,
  output logic                    out_bit_o,
  output logic                    out_drive_o
);
  logic [2:0]         pos;
  logic               hdr_done;
  logic               rd_mode;
  logic [`BYTE_W-1:0] in_shift;
  logic [`BYTE_W-1:0] out_shift;

  wire               byte_end = (pos == `LAST_BIT);
  wire [`BYTE_W-1:0] in_byte  = {in_shift[`BYTE_W-2:0], sdi_i};

  // ----------------------------------------
  // Frame state, cleared by the chip select
  // ----------------------------------------
  // Clock is parked high outside frames, so chip select ends the frame [RL15]
  always_ff @(posedge port_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      pos      <= `FIRST_BIT;
      hdr_done <= 1'b0;
      rd_mode  <= 1'b0;
      in_shift <= '0;
    end
    else
    begin
      in_shift <= in_byte; // [RL16] [RL19]
      pos      <= pos + 3'h1; // [RL17]
      if (byte_end && !hdr_done)
      begin
        hdr_done <= 1'b1;
        rd_mode  <= in_byte[`BYTE_W-1]; // [RL18]
      end
    end
  end

  // ----------------------------------------
  // Byte events toward the system clock
  // ----------------------------------------
  // Word stays put for a whole byte time, long enough for the far side
  always_ff @(posedge port_clk_i or posedge link_rst_i)
  begin
    if (link_rst_i)
    begin
      event_toggle_o <= 1'b0;
      event_header_o <= 1'b0;
      event_word_o   <= '0;
    end
    else if (byte_end)
    begin
      event_toggle_o <= !event_toggle_o; // [RL17]
      event_header_o <= !hdr_done;
      event_word_o   <= in_byte;
    end
  end

  // ----------------------------------------
  // Read data, changed on the falling edge
  // ----------------------------------------
  always_ff @(negedge port_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      out_shift   <= '0;
      out_drive_o <= 1'b0;
    end
    else if (hdr_done && rd_mode)
    begin
      out_drive_o <= 1'b1; // [RL18]
      out_shift   <= (pos == `FIRST_BIT) ? read_word_i : {out_shift[`BYTE_W-2:0], 1'b0}; // [RL16] [RL19]
    end
  end

  assign out_bit_o = out_shift[`BYTE_W-1];

  a_event_per_byte : // [RL17]
  assert property (@(posedge port_clk_i) disable iff (cs_n_i)
    byte_end |=> (event_toggle_o != $past(event_toggle_o)))
    else $error("byte end raised no event");

  a_header_msb_first : // [RL19]
  assert property (@(posedge port_clk_i) disable iff (cs_n_i)
    (byte_end && !hdr_done) |=> event_header_o && (event_word_o == $past(in_byte)))
    else $error("header byte not passed on");

  a_read_drive_start : // [RL18]
  assert property (@(negedge port_clk_i) disable iff (cs_n_i)
    (hdr_done && rd_mode && pos == `FIRST_BIT) |=> out_drive_o)
    else $error("read data not driven at bit 8");

endmodule : spi_link_engine
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the dual serial register port
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        two_wire_disable_i = 1'b0;
  logic        three_wire_select_i = 1'b0;
  logic        auto_increment_i = 1'b0;
  logic        addr_pin = 1'b1;
  logic        sda_o, sda_oe_n_o, scl_o, scl_oe_n_o, sdo_o, sdo_oe_n_o;
  logic        reg_write_o, reg_read_o, bus_busy_o, host_sda, host_scl, cs_n;
  logic [7:0]  reg_index_o, reg_wdata_o;
  logic [7:0]  mem [256];
  logic [15:0] seed = 16'h0013;
  logic [15:0] exp_wr [$];
  logic [15:0] w_exp;
  int          check_count = 0;
  int          bad_count = 0;
  int          cycles = 0;
  wire logic       sda_line = host_sda & (sda_oe_n_o | sda_o);
  wire logic       scl_line = host_scl & (scl_oe_n_o | scl_o);
  wire logic       sdo_line = sdo_oe_n_o ? addr_pin : sdo_o;
  wire logic [7:0] reg_rdata = mem[reg_index_o];
  always #10 clk_i = ~clk_i;
  dual_serial_register_port i_dual_serial_register_port (
    .clk_i                (clk_i),
    .resetn_i             (resetn_i),
    .serial_port_clock_i  (scl_line),
    .chip_select_n_i      (cs_n),
    .sda_i                (sda_line),
    .sda_o                (sda_o),
    .sda_oe_n_o           (sda_oe_n_o),
    .scl_o                (scl_o),
    .scl_oe_n_o           (scl_oe_n_o),
    .address_select_pin_i (sdo_line),
    .sdo_o                (sdo_o),
    .sdo_oe_n_o           (sdo_oe_n_o),
    .two_wire_disable_i   (two_wire_disable_i),
    .three_wire_select_i  (three_wire_select_i),
    .auto_increment_i     (auto_increment_i),
    .reg_index_o          (reg_index_o),
    .reg_wdata_o          (reg_wdata_o),
    .reg_write_o          (reg_write_o),
    .reg_read_o           (reg_read_o),
    .reg_rdata_i          (reg_rdata),
    .bus_busy_o           (bus_busy_o)
  );
  host_bus_model i_host_bus_model (
    .sda_line_i  (sda_line),
    .scl_line_i  (scl_line),
    .sdo_line_i  (sdo_line),
    .sda_drive_o (host_sda),
    .scl_drive_o (host_scl),
    .cs_n_o      (cs_n)
  );
  // --------------------------------------------------------------
  // Bench model and helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd
  task automatic summarize();
    `CHECK("writes left", 0, exp_wr.size())
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // A write with nothing queued compares against unknown and fails
  // Sampled on the falling edge, where the write pulse has settled
  always @(negedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      summarize();
    end
    if (reg_write_o === 1'b1)
    begin
      w_exp = (exp_wr.size() > 0) ? exp_wr.pop_front() : 16'hxxxx;
      `CHECK("register write", w_exp, {reg_index_o, reg_wdata_o})
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : settle
  task automatic done(input string name);
    $display("test %s ended, mismatches %0d", name, bad_count);
  endtask : done
  task automatic i2c_head(input logic [7:0] idx);
    logic [7:0] rx;
    logic       ack;
    i_host_bus_model.i2c_start();
    i_host_bus_model.i2c_byte({6'h35, addr_pin, 1'b0}, 1'b1, rx, ack);
    `CHECK("address ack", 1'b0, ack)
    `CHECK("bus busy", 1'b1, bus_busy_o)
    i_host_bus_model.i2c_byte(idx, 1'b1, rx, ack);
    `CHECK("index ack", 1'b0, ack)
  endtask : i2c_head
  task automatic i2c_end();
    i_host_bus_model.i2c_stop();
    settle(10);
    `CHECK("bus free", 1'b0, bus_busy_o)
  endtask : i2c_end
  task automatic i2c_access(input logic rd, input logic [7:0] idx, input int n);
    logic [7:0] a, d, rx;
    logic       ack;
    a = idx;
    i2c_head(idx);
    if (rd)
    begin
      i_host_bus_model.i2c_start();
      i_host_bus_model.i2c_byte({6'h35, addr_pin, 1'b1}, 1'b1, rx, ack);
      `CHECK("read address ack", 1'b0, ack)
    end
    for (int k = 0; k < n; k++)
    begin
      d = rd ? 8'hff : rnd();
      if (!rd)
        exp_wr.push_back({a, d});
      i_host_bus_model.i2c_byte(d, rd ? (k == n - 1) : 1'b1, rx, ack);
      if (rd)
        `CHECK("read data", mem[a], rx)
      else
        `CHECK("data ack", 1'b0, ack)
      a = a + {7'h00, auto_increment_i};
    end
    if (rd)
      `CHECK("release after no ack", 1'b1, sda_oe_n_o)
    i2c_end();
  endtask : i2c_access
  task automatic i2c_refused(input logic [7:0] addr, input string name);
    logic [7:0] rx;
    logic       ack;
    i_host_bus_model.i2c_start();
    i_host_bus_model.i2c_byte(addr, 1'b1, rx, ack);
    `CHECK(name, 1'b1, ack)
    i_host_bus_model.i2c_stop();
    settle(10);
  endtask : i2c_refused
  task automatic spi_access(input logic rd, input logic [6:0] idx, input int n);
    logic [7:0] a, d, rx;
    a = {1'b0, idx};
    i_host_bus_model.spi_select(1'b1);
    i_host_bus_model.spi_byte({rd, idx}, three_wire_select_i, rx);
    for (int k = 0; k < n; k++)
    begin
      d = rd ? 8'hff : rnd();
      if (!rd)
        exp_wr.push_back({a, d});
      i_host_bus_model.spi_byte(d, three_wire_select_i, rx);
      if (rd)
        `CHECK("spi read data", mem[a], rx)
      a = a + {7'h00, auto_increment_i};
    end
    `CHECK("busy during spi", 1'b0, bus_busy_o)
    if (rd)
      `CHECK("four wire drive", three_wire_select_i, sdo_oe_n_o)
    i_host_bus_model.spi_select(1'b0);
    settle(20);
    `CHECK("spi release", 2'b11, {sdo_oe_n_o, sda_oe_n_o})
  endtask : spi_access
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = rnd();
    settle(10);
    resetn_i <= 1'b1;
    settle(5);
    auto_increment_i <= 1'b1;
    settle(4);
    i2c_access(1'b0, 8'h10, 2);
    done("two-wire write");
    addr_pin <= 1'b0;
    settle(4);
    i2c_access(1'b1, 8'h20, 3);
    auto_increment_i <= 1'b0;
    settle(4);
    i2c_access(1'b1, 8'h30, 2);
    i2c_access(1'b0, 8'h31, 2);
    done("two-wire read");
    i2c_refused({6'h34, addr_pin, 1'b0}, "foreign address ack");
    two_wire_disable_i <= 1'b1;
    settle(4);
    i2c_refused({6'h35, addr_pin, 1'b0}, "disabled slave ack");
    two_wire_disable_i <= 1'b0;
    settle(4);
    done("refusals");
    spi_access(1'b0, 7'h05, 2);
    auto_increment_i <= 1'b1;
    settle(4);
    spi_access(1'b1, 7'h40, 2);
    spi_access(1'b0, 7'h50, 3);
    three_wire_select_i <= 1'b1;
    settle(4);
    spi_access(1'b1, 7'h11, 2);
    done("spi");
    summarize();
  end
endmodule : testbench
`default_nettype wire
